// ==== omf_mode_ctrl.sv ====
// Operating-mode, fault reaction and wake controller
`timescale 1ns/10ps
`default_nettype none
`include "omf_cfg.svh"
module omf_mode_ctrl
    import omf_pkg::*;
#(
    parameter int TSD_FILT_CYC = `OMF_TSD_FILT_CYC,
    parameter int CWAKE_PERIOD = 1000,
    parameter int CWAKE_ON = 100
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [1:0] i_mode_cmd,
    input wire logic i_mode_cmd_valid,
    input wire logic [4:0] i_wake_src_en,
    input wire logic i_cyclic_sense_en,
    input wire logic i_cyclic_wake_en,
    input wire logic i_wake_input_pin,
    input wire logic i_bus_wake,
    input wire logic i_ls_short_braking,
    input wire logic i_main_reg_undervolt,
    input wire logic i_main_reg_overvolt,
    input wire logic i_main_reg_overvolt_reaction_sel,
    input wire logic i_main_reg_short_gnd,
    input wire logic i_thermal_shutdown_stage_two,
    input wire logic i_wd_fail,
    input wire logic i_periph_fault,
    input wire logic i_hs_fault,
    input wire logic i_status_clear,
    output logic [2:0] o_mode,
    output logic o_reset_out_low_active,
    output logic o_irq_out_low_active,
    output logic o_spi_fail,
    output logic o_restart_flag,
    output logic o_failure_flag,
    output logic [4:0] o_wake_status,
    output logic o_periph_fault_flag,
    output logic o_high_side_output,
    output logic o_main_regulator_on,
    output logic o_wd_long_window,
    output logic o_wd_period_default
);
    localparam logic [15:0] RESTART_CYC = 16'(`OMF_RESTART_CYC);

    omf_mode_e mode_q;
    omf_mode_e mode_d;
    logic [15:0] rst_cnt_q;
    logic [15:0] rst_cnt_d;
    logic [31:0] tsd_cnt_q;
    logic [31:0] tsd_cnt_d;
    logic [31:0] cw_cnt_q;
    logic [31:0] cw_cnt_d;
    logic [2:0] wd_cnt_q;
    logic [2:0] wd_cnt_d;
    logic [2:0] uv_cnt_q;
    logic [2:0] uv_cnt_d;
    logic sleep_cmd_q;
    logic sleep_cmd_d;
    logic spi_fail_q;
    logic spi_fail_d;
    logic restart_q;
    logic restart_d;
    logic failure_q;
    logic failure_d;
    logic [4:0] wake_status_reg_q;
    logic [4:0] wake_status_reg_d;
    logic pf_q;
    logic pf_d;
    logic irq_q;
    logic irq_d;
    logic uv_prev_q;
    logic hs_dis_q;
    logic hs_dis_d;
    logic wd_win_q;
    logic wd_win_d;
    logic on_phase;
    logic pin_wake;
    logic cw_tick;
    logic [4:0] wk_evt;
    logic fs_fault;
    logic rs_fault;
    logic uv_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Wake timers
    assign on_phase = i_cyclic_sense_en && !hs_dis_q && (cw_cnt_q < 32'(CWAKE_ON));
    assign cw_tick = i_cyclic_wake_en && !hs_dis_q && (cw_cnt_q == 32'(CWAKE_PERIOD - 1));

    omf_wake_sense u_sense (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_wake_input_pin(i_wake_input_pin),
        .i_cyclic_sense_en(i_cyclic_sense_en),
        .i_on_phase(on_phase),
        .o_wake_event(pin_wake),
        .o_level()
    );

    // Static and cyclic sense share the pin; the cause bit follows the mode
    always_comb begin
        wk_evt = 5'h0;
        wk_evt[`OMF_WK_BUS] = i_bus_wake;
        wk_evt[`OMF_WK_PIN] = pin_wake && !i_cyclic_sense_en;
        wk_evt[`OMF_WK_CSENSE] = pin_wake && i_cyclic_sense_en;
        wk_evt[`OMF_WK_CWAKE] = cw_tick; // [RULE21]
        wk_evt[`OMF_WK_LSSHORT] = i_ls_short_braking;
    end

    assign uv_rise = i_main_reg_undervolt && !uv_prev_q;
    assign fs_fault = i_thermal_shutdown_stage_two || i_main_reg_short_gnd
        || (i_main_reg_overvolt && i_main_reg_overvolt_reaction_sel); // [RULE17]
    assign rs_fault = i_main_reg_undervolt || i_wd_fail
        || (i_main_reg_overvolt && !i_main_reg_overvolt_reaction_sel); // [RULE16]

    ////////////////////////////////////////////////////////////////////////////
    // Mode machine
    always_comb begin
        mode_d = mode_q;
        rst_cnt_d = rst_cnt_q;
        tsd_cnt_d = tsd_cnt_q;
        cw_cnt_d = (cw_cnt_q >= 32'(CWAKE_PERIOD - 1)) ? 32'h0 : cw_cnt_q + 32'h1;
        wd_cnt_d = i_wd_fail ? wd_cnt_q + 3'h1 : wd_cnt_q;
        uv_cnt_d = uv_rise ? uv_cnt_q + 3'h1 : uv_cnt_q;
        sleep_cmd_d = 1'b0;
        spi_fail_d = spi_fail_q && !i_status_clear;
        restart_d = restart_q && !i_status_clear;
        failure_d = failure_q && !i_status_clear;
        wake_status_reg_d = i_status_clear ? 5'h0 : wake_status_reg_q;
        pf_d = (pf_q && !i_status_clear) || i_periph_fault || i_hs_fault; // [RULE15]
        irq_d = 1'b0;
        hs_dis_d = hs_dis_q;
        wd_win_d = 1'b0;
        if (!i_cyclic_sense_en && !i_cyclic_wake_en) begin
            hs_dis_d = 1'b0;
        end
        if (i_hs_fault || fs_fault || rs_fault) begin
            hs_dis_d = 1'b1; // [RULE6]
        end
        case (mode_q)
            OMF_NORMAL, OMF_STOP: begin
                irq_d = i_periph_fault || i_hs_fault || pin_wake || cw_tick; // [RULE15] [RULE22]
                wake_status_reg_d = wake_status_reg_d | (wk_evt & i_wake_src_en);
                if (fs_fault || wd_cnt_d >= `OMF_FAIL_LIMIT
                        || uv_cnt_d >= `OMF_FAIL_LIMIT) begin // [RULE18]
                    mode_d = OMF_FAILSAFE;
                end else if (rs_fault) begin
                    mode_d = OMF_RESTART;
                end else if (i_mode_cmd_valid) begin
                    if (i_mode_cmd == `OMF_CMD_SLEEP) begin // [RULE1]
                        sleep_cmd_d = 1'b1;
                        if (mode_q == OMF_STOP || i_wake_src_en == 5'h0) begin
                            spi_fail_d = 1'b1; // [RULE5] [RULE23]
                            mode_d = OMF_RESTART;
                        end else begin
                            mode_d = OMF_SLEEP;
                        end
                    end else if (i_mode_cmd == `OMF_CMD_STOP && mode_q == OMF_NORMAL) begin
                        mode_d = OMF_STOP;
                    end else if (i_mode_cmd == `OMF_CMD_NORMAL) begin
                        mode_d = OMF_NORMAL;
                    end
                end
            end
            OMF_SLEEP: begin
                wake_status_reg_d = wake_status_reg_d | (wk_evt & i_wake_src_en);
                if (fs_fault) begin
                    mode_d = OMF_FAILSAFE; // [RULE3]
                end else if (rs_fault) begin
                    mode_d = OMF_RESTART; // [RULE2]
                end else if (|(wk_evt & i_wake_src_en) || i_ls_short_braking) begin
                    mode_d = OMF_RESTART; // [RULE7] [RULE8]
                end
            end
            OMF_RESTART: begin
                rst_cnt_d = rst_cnt_q + 16'h1;
                if (fs_fault) begin
                    mode_d = OMF_FAILSAFE;
                end else if (rst_cnt_q >= RESTART_CYC - 16'h1) begin
                    mode_d = OMF_NORMAL; // [RULE11]
                    wd_win_d = 1'b1; // [RULE12]
                end
            end
            default: begin
                hs_dis_d = 1'b1;
                wake_status_reg_d = wake_status_reg_d | (wk_evt & 5'h13);
                if (i_thermal_shutdown_stage_two) begin
                    tsd_cnt_d = 32'h0;
                end else if (tsd_cnt_q < 32'(TSD_FILT_CYC)) begin
                    tsd_cnt_d = tsd_cnt_q + 32'h1;
                end
                if (!i_main_reg_short_gnd && (i_bus_wake || pin_wake || i_ls_short_braking
                        || tsd_cnt_q >= 32'(TSD_FILT_CYC))) begin
                    mode_d = OMF_RESTART; // [RULE13]
                    failure_d = 1'b1; // [RULE14]
                end
            end
        endcase
        if (mode_d == OMF_RESTART && mode_q != OMF_RESTART) begin
            restart_d = 1'b1; // [RULE10]
            rst_cnt_d = 16'h0;
        end
        if (mode_d == OMF_FAILSAFE && mode_q != OMF_FAILSAFE) begin
            tsd_cnt_d = 32'h0;
            wd_cnt_d = 3'h0;
            uv_cnt_d = 3'h0;
        end
        if (mode_d == OMF_NORMAL && mode_q == OMF_RESTART) begin
            wd_cnt_d = wd_cnt_q;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            mode_q <= OMF_NORMAL;
            rst_cnt_q <= 16'h0;
            tsd_cnt_q <= 32'h0;
            cw_cnt_q <= 32'h0;
            wd_cnt_q <= 3'h0;
            uv_cnt_q <= 3'h0;
            sleep_cmd_q <= 1'b0;
            spi_fail_q <= 1'b0;
            restart_q <= 1'b0;
            failure_q <= 1'b0;
            wake_status_reg_q <= 5'h0;
            pf_q <= 1'b0;
            irq_q <= 1'b0;
            uv_prev_q <= 1'b0;
            hs_dis_q <= 1'b1;
            wd_win_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            rst_cnt_q <= rst_cnt_d;
            tsd_cnt_q <= tsd_cnt_d;
            cw_cnt_q <= cw_cnt_d;
            wd_cnt_q <= wd_cnt_d;
            uv_cnt_q <= uv_cnt_d;
            sleep_cmd_q <= sleep_cmd_d;
            spi_fail_q <= spi_fail_d;
            restart_q <= restart_d;
            failure_q <= failure_d;
            wake_status_reg_q <= wake_status_reg_d;
            pf_q <= pf_d;
            irq_q <= irq_d;
            uv_prev_q <= i_main_reg_undervolt;
            hs_dis_q <= hs_dis_d;
            wd_win_q <= wd_win_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_mode = mode_q;
    // Reset also drops with the sleep command so the host sees it at once
    assign o_reset_out_low_active = !(mode_q == OMF_RESTART || mode_q == OMF_SLEEP
        || mode_q == OMF_FAILSAFE || sleep_cmd_q); // [RULE4] [RULE9]
    assign o_irq_out_low_active = !irq_q;
    assign o_spi_fail = spi_fail_q;
    assign o_restart_flag = restart_q;
    assign o_failure_flag = failure_q;
    assign o_wake_status = wake_status_reg_q;
    assign o_periph_fault_flag = pf_q;
    assign o_high_side_output = on_phase;
    assign o_main_regulator_on = !(mode_q == OMF_SLEEP || mode_q == OMF_FAILSAFE);
    assign o_wd_long_window = wd_win_q;
    assign o_wd_period_default = wd_win_q;

    AST_NO_SELF_SLEEP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ($past(mode_q) == OMF_NORMAL && mode_q == OMF_SLEEP) |-> $past(i_mode_cmd_valid))
        else $error("sleep entered without command"); // [RULE1]
    AST_SLEEP_RST_LOW: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_mode_cmd_valid && i_mode_cmd == `OMF_CMD_SLEEP && mode_q == OMF_NORMAL
            && !rs_fault && !fs_fault && wd_cnt_d < 3'h4 && uv_cnt_d < 3'h4)
        |=> !o_reset_out_low_active)
        else $error("reset not low after sleep command"); // [RULE4]
    AST_NO_SRC_FAIL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (mode_q == OMF_NORMAL && i_mode_cmd_valid && i_mode_cmd == `OMF_CMD_SLEEP
            && i_wake_src_en == 5'h0 && !rs_fault && !fs_fault && wd_cnt_d < 3'h4
            && uv_cnt_d < 3'h4) |=> (o_spi_fail && mode_q == OMF_RESTART))
        else $error("sleep without wake source not rejected"); // [RULE5]
    AST_STOP_SLEEP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ($past(mode_q) == OMF_STOP) |-> mode_q != OMF_SLEEP)
        else $error("stop went to sleep"); // [RULE23]
    AST_RESTART_RST: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        mode_q == OMF_RESTART |-> !o_reset_out_low_active)
        else $error("reset high in restart"); // [RULE9]
    AST_RESTART_FLAG: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ($rose(mode_q == OMF_RESTART) && !$past(i_status_clear)) |-> o_restart_flag)
        else $error("restart entry not recorded"); // [RULE10]
    AST_RESTART_EXIT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ($past(mode_q) == OMF_RESTART && mode_q == OMF_NORMAL) |-> o_wd_long_window)
        else $error("no long window at restart exit"); // [RULE12]
    AST_FS_FAILURE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ($past(mode_q) == OMF_FAILSAFE && mode_q != OMF_FAILSAFE) |-> o_failure_flag)
        else $error("failure bit not set on fail-safe exit"); // [RULE14]
    AST_FS_ENTRY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (mode_q == OMF_NORMAL && i_main_reg_short_gnd) |=> mode_q == OMF_FAILSAFE)
        else $error("regulator short did not enter fail-safe"); // [RULE17]
    AST_PERIPH_STAY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (mode_q == OMF_NORMAL && !rs_fault && !fs_fault && !i_mode_cmd_valid
            && wd_cnt_d < 3'h4 && uv_cnt_d < 3'h4) |=> mode_q == OMF_NORMAL)
        else $error("mode changed without cause"); // [RULE15]
endmodule : omf_mode_ctrl
`default_nettype wire

// ==== omf_cfg.svh ====
// Constants of the operating-mode and wake controller
// Overview of operation
// [RULE1] Normal to Sleep only by host command
// [RULE2] Undervolt or restart-overvolt at Sleep entry: Restart
// [RULE3] Thermal or failsafe-overvolt at Sleep entry: Fail-Safe
// [RULE4] Reset output low once Sleep command received
// [RULE5] Sleep with no wake source: error, Restart
// [RULE6] Failures disable high-side outputs and cyclic timers
// [RULE7] Sleep wake events lead to Restart
// [RULE8] Braking low-side short in Sleep: Restart
// [RULE9] Reset output low throughout Restart
// [RULE10] Restart entry and wake cause recorded
// [RULE11] Restart goes to Normal automatically
// [RULE12] Restart exit: long watchdog window, period default
// [RULE13] Fail-Safe exits on wake, thermal clear, short
// [RULE14] Leaving Fail-Safe sets failure bit
// [RULE15] Peripheral faults only flag and interrupt
// [RULE16] Normal/Stop faults cause Restart
// [RULE17] Thermal, regulator short, failsafe-overvolt: Fail-Safe
// [RULE18] Four consecutive watchdog or undervolt failures: Fail-Safe; code counts all four, cleared only on Fail-Safe entry
// [RULE19] Static sense continuous, cyclic only in on-time
// [RULE20] Cyclic sense samples at end of on-phase
// [RULE21] Cyclic wake timer raises periodic interrupts
// [RULE22] Sensed edge: interrupt, or regulator on in Sleep
// [RULE23] Stop to Sleep rejected: error, Restart
// [RULE24] Host clears wake flags, enables a source first
`ifndef OMF_CFG_SVH
`define OMF_CFG_SVH
`define OMF_FAIL_LIMIT 3'h4
`define OMF_RESTART_NS 1000
`define OMF_CLK_NS 5
`define OMF_RESTART_CYC ((`OMF_RESTART_NS + `OMF_CLK_NS - 1) / `OMF_CLK_NS)
`define OMF_TSD_FILT_CYC 200000000
`define OMF_CMD_NONE 2'h0
`define OMF_CMD_NORMAL 2'h1
`define OMF_CMD_STOP 2'h2
`define OMF_CMD_SLEEP 2'h3
`define OMF_WK_BUS 0
`define OMF_WK_PIN 1
`define OMF_WK_CSENSE 2
`define OMF_WK_CWAKE 3
`define OMF_WK_LSSHORT 4
`endif

// ==== omf_pkg.sv ====
// Types of the operating-mode and wake controller
package omf_pkg;
    typedef enum logic [2:0] {
        OMF_NORMAL = 3'h0,
        OMF_STOP = 3'h1,
        OMF_SLEEP = 3'h3,
        OMF_RESTART = 3'h2,
        OMF_FAILSAFE = 3'h6
    } omf_mode_e;
endpackage : omf_pkg

// ==== omf_wake_sense.sv ====
// Wake input synchroniser and cyclic-sense sampler
`timescale 1ns/10ps
`default_nettype none
`include "omf_cfg.svh"
module omf_wake_sense
    import omf_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_wake_input_pin,
    input wire logic i_cyclic_sense_en,
    input wire logic i_on_phase,
    output logic o_wake_event,
    output logic o_level
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic level_q;
    logic level_d;
    logic on_prev_q;
    logic on_prev_d;
    logic wake_q;
    logic wake_d;
    logic end_of_on;

    assign end_of_on = on_prev_q && !i_on_phase;

    always_comb begin
        sync_d = {sync_q[1:0], i_wake_input_pin};
        on_prev_d = i_on_phase;
        level_d = level_q;
        wake_d = 1'b0;
        if (sync_q[2] == sync_q[1]) begin
            // Static sense sees every settled change; cyclic only at on-phase end
            if (!i_cyclic_sense_en) begin // [RULE19]
                level_d = sync_q[2];
                wake_d = (sync_q[2] != level_q);
            end else if (end_of_on) begin // [RULE20]
                level_d = sync_q[2];
                wake_d = (sync_q[2] != level_q); // [RULE22]
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sync_q <= 3'h0;
            level_q <= 1'b0;
            on_prev_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            level_q <= level_d;
            on_prev_q <= on_prev_d;
            wake_q <= wake_d;
        end
    end

    assign o_wake_event = wake_q;
    assign o_level = level_q;

    AST_CYC_ONLY_END: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_cyclic_sense_en && !$past(end_of_on) && $past(i_cyclic_sense_en)) |-> !o_wake_event)
        else $error("cyclic wake outside on-phase end"); // [RULE20]
endmodule : omf_wake_sense
`default_nettype wire

// ==== omf_host_model.sv ====
// Host model that issues mode commands and clears the status flags
`timescale 1ns/10ps
`default_nettype none
`include "omf_cfg.svh"
module omf_host_model (
    input wire logic i_clock,
    output logic [1:0] o_mode_cmd,
    output logic o_mode_cmd_valid,
    output logic o_status_clear
);
    initial begin
        o_mode_cmd = `OMF_CMD_NONE;
        o_mode_cmd_valid = 1'b0;
        o_status_clear = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Caller stands just after a rising edge; the request is taken at the next
    // The host requests mode changes only through this explicit command
    task automatic send_cmd(input logic [1:0] cmd);
        o_mode_cmd = cmd;
        o_mode_cmd_valid = 1'b1;
        @(posedge i_clock);
        #1;
        o_mode_cmd_valid = 1'b0;
        o_mode_cmd = `OMF_CMD_NONE;
    endtask : send_cmd

    // Wake flags are cleared before any Sleep request
    task automatic clear_flags();
        o_status_clear = 1'b1;
        @(posedge i_clock);
        #1;
        o_status_clear = 1'b0;
    endtask : clear_flags
endmodule : omf_host_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench of the operating-mode and wake controller
`timescale 1ns/10ps
`default_nettype none
`include "omf_cfg.svh"
module testbench
    import omf_pkg::*;
;
    logic i_clock, i_rst_n, pin, bus_wake, ls_short, uv, ov, ov_sel, tsd, wd_fail, periph;
    logic [4:0] wake_en, wake_status;
    logic [1:0] cmd;
    logic cmd_valid, st_clr, rst_out, irq, spi_fail, restart_flag, failure_flag;
    logic periph_flag, hs_out, reg_on, wd_long, wd_def, seen, sgnd, hsf, cwake;
    logic [2:0] mode;
    int fails = 0;
    int cmp_count = 0;

    // Short thermal filter keeps the Fail-Safe exit within a brief run
    omf_mode_ctrl #(.TSD_FILT_CYC(50), .CWAKE_PERIOD(40), .CWAKE_ON(8)) dut_u (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_mode_cmd(cmd), .i_mode_cmd_valid(cmd_valid),
        .i_wake_src_en(wake_en), .i_cyclic_sense_en(1'b0), .i_cyclic_wake_en(cwake),
        .i_wake_input_pin(pin), .i_bus_wake(bus_wake), .i_ls_short_braking(ls_short),
        .i_main_reg_undervolt(uv), .i_main_reg_overvolt(ov),
        .i_main_reg_overvolt_reaction_sel(ov_sel), .i_main_reg_short_gnd(sgnd),
        .i_thermal_shutdown_stage_two(tsd), .i_wd_fail(wd_fail), .i_periph_fault(periph),
        .i_hs_fault(hsf), .i_status_clear(st_clr), .o_mode(mode),
        .o_reset_out_low_active(rst_out), .o_irq_out_low_active(irq), .o_spi_fail(spi_fail),
        .o_restart_flag(restart_flag), .o_failure_flag(failure_flag),
        .o_wake_status(wake_status), .o_periph_fault_flag(periph_flag),
        .o_high_side_output(hs_out), .o_main_regulator_on(reg_on),
        .o_wd_long_window(wd_long), .o_wd_period_default(wd_def)
    );
    omf_host_model host_u (
        .i_clock(i_clock), .o_mode_cmd(cmd), .o_mode_cmd_valid(cmd_valid),
        .o_status_clear(st_clr)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_bit(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check_bit

    task automatic check_mode(input logic [2:0] got, input omf_mode_e exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check_mode

    task automatic tick();
        @(posedge i_clock);
        #1;
    endtask : tick

    task automatic wait_mode(input omf_mode_e m);
        int n;
        n = 0;
        while (mode !== m && n < 300) begin
            tick();
            n++;
        end
        check_mode(mode, m, "expected mode not reached");
    endtask : wait_mode

    // Whole Restart span is watched, then the hand-over to Normal
    task automatic through_restart();
        int n;
        logic pulse;
        n = 0;
        pulse = 1'b0;
        while (mode === OMF_RESTART && n < 400) begin
            check_bit(rst_out, 1'b0, "reset output released in restart");
            tick();
            n++;
        end
        repeat (2) begin
            pulse = pulse | (wd_long & wd_def);
            tick();
        end
        check_bit(n >= 199 && n <= 201, 1'b1, "restart length wrong");
        check_mode(mode, OMF_NORMAL, "no automatic return to normal");
        check_bit(rst_out, 1'b1, "reset output not released");
        check_bit(pulse, 1'b1, "watchdog window not restarted");
    endtask : through_restart

    task automatic irq_within();
        seen = 1'b0;
        repeat (12) begin
            if (irq === 1'b0) begin
                seen = 1'b1;
            end
            tick();
        end
    endtask : irq_within

    task automatic pulse_in(ref logic sig);
        sig = 1'b1;
        tick();
        sig = 1'b0;
    endtask : pulse_in

    ////////////////////////////////////////////////////////////////////////////
    task automatic sc_periph();
        host_u.clear_flags();
        pulse_in(periph);
        irq_within();
        check_bit(seen, 1'b1, "no interrupt on peripheral fault");
        check_mode(mode, OMF_NORMAL, "peripheral fault changed mode");
        check_bit(periph_flag, 1'b1, "peripheral flag not set");
    endtask : sc_periph

    task automatic sc_pin();
        wake_en = 5'h02;
        host_u.clear_flags();
        pin = ~pin;
        irq_within();
        check_bit(seen, 1'b1, "no interrupt on pin edge");
        check_bit(wake_status[1], 1'b1, "static pin wake not flagged");
        check_mode(mode, OMF_NORMAL, "pin edge changed mode");
    endtask : sc_pin

    // Timer period is 40 cycles, so one tick must fall inside 45
    task automatic sc_cwake();
        wake_en = 5'h08;
        host_u.clear_flags();
        cwake = 1'b1;
        seen = 1'b0;
        repeat (45) begin
            if (irq === 1'b0) begin
                seen = 1'b1;
            end
            tick();
        end
        cwake = 1'b0;
        check_bit(seen, 1'b1, "no cyclic wake interrupt");
        check_bit(wake_status[3], 1'b1, "cyclic wake not flagged");
        check_mode(mode, OMF_NORMAL, "cyclic wake changed mode");
    endtask : sc_cwake

    task automatic sc_hs_short();
        host_u.clear_flags();
        pulse_in(hsf);
        irq_within();
        check_bit(seen, 1'b1, "no interrupt on high-side fault");
        check_mode(mode, OMF_NORMAL, "high-side fault changed mode");
        check_bit(periph_flag, 1'b1, "high-side fault not flagged");
        sgnd = 1'b1;
        tick();
        check_mode(mode, OMF_FAILSAFE, "regulator short not fail-safe");
        check_bit(hs_out, 1'b0, "high side on in fail-safe");
        sgnd = 1'b0;
        pulse_in(bus_wake);
        wait_mode(OMF_RESTART);
        check_bit(failure_flag, 1'b1, "failure bit not set");
        through_restart();
    endtask : sc_hs_short

    // Sleep entry with a given source, then a wake from it
    task automatic sc_sleep_wake(input logic [4:0] en, input int bit_no);
        wake_en = en;
        host_u.clear_flags();
        host_u.send_cmd(`OMF_CMD_SLEEP);
        check_mode(mode, OMF_SLEEP, "sleep not entered");
        check_bit(rst_out, 1'b0, "reset output high after sleep command");
        check_bit(reg_on, 1'b0, "regulator on in sleep");
        repeat (5) tick();
        check_mode(mode, OMF_SLEEP, "sleep left without wake");
        if (bit_no == 0) pulse_in(bus_wake);
        else pulse_in(ls_short);
        wait_mode(OMF_RESTART);
        check_bit(restart_flag, 1'b1, "restart entry not recorded");
        check_bit(wake_status[bit_no], 1'b1, "wake cause not recorded");
        through_restart();
    endtask : sc_sleep_wake

    task automatic sc_refused(input logic via_stop);
        wake_en = via_stop ? 5'h01 : 5'h00;
        host_u.clear_flags();
        check_bit(spi_fail, 1'b0, "error flag not cleared");
        if (via_stop) begin
            host_u.send_cmd(`OMF_CMD_STOP);
            check_mode(mode, OMF_STOP, "stop not entered");
        end
        host_u.send_cmd(`OMF_CMD_SLEEP);
        wait_mode(OMF_RESTART);
        check_bit(spi_fail, 1'b1, "error flag not set");
        through_restart();
    endtask : sc_refused

    task automatic sc_sleep_fault(input logic thermal);
        wake_en = 5'h01;
        host_u.clear_flags();
        if (thermal) tsd = 1'b1;
        else uv = 1'b1;
        host_u.send_cmd(`OMF_CMD_SLEEP);
        uv = 1'b0;
        if (thermal) begin
            check_mode(mode, OMF_FAILSAFE, "thermal at sleep entry");
            check_bit(reg_on, 1'b0, "regulator on in fail-safe");
            repeat (10) tick();
            tsd = 1'b0;
            wait_mode(OMF_RESTART);
            check_bit(failure_flag, 1'b1, "failure bit not set");
        end else begin
            check_mode(mode, OMF_RESTART, "undervolt at sleep entry");
        end
        through_restart();
    endtask : sc_sleep_fault

    task automatic sc_overvolt();
        host_u.clear_flags();
        ov_sel = 1'b1;
        pulse_in(ov);
        wait_mode(OMF_FAILSAFE);
        pulse_in(bus_wake);
        wait_mode(OMF_RESTART);
        check_bit(failure_flag, 1'b1, "failure bit not set");
        through_restart();
        ov_sel = 1'b0;
        pulse_in(ov);
        wait_mode(OMF_RESTART);
        through_restart();
    endtask : sc_overvolt

    task automatic sc_wd_count();
        repeat (3) begin
            pulse_in(wd_fail);
            wait_mode(OMF_RESTART);
            through_restart();
        end
        pulse_in(wd_fail);
        wait_mode(OMF_FAILSAFE);
        host_u.clear_flags();
        pin = ~pin;
        wait_mode(OMF_RESTART);
        check_bit(failure_flag, 1'b1, "failure bit not set");
        through_restart();
    endtask : sc_wd_count

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    initial begin
        #100000;
        fails++;
        $display("unexpected at %0t: run did not finish", $time);
        report_and_stop();
    end

    initial begin
        {i_rst_n, pin, bus_wake, ls_short, uv, ov, ov_sel, tsd, wd_fail, periph} = '0;
        {sgnd, hsf, cwake} = 3'h0;
        wake_en = 5'h00;
        repeat (20) @(posedge i_clock);
        #1;
        i_rst_n = 1'b1;
        sc_periph();
        sc_pin();
        sc_cwake();
        sc_sleep_wake(5'h01, 0);
        sc_sleep_wake(5'h10, 4);
        sc_refused(1'b0);
        sc_refused(1'b1);
        sc_sleep_fault(1'b0);
        sc_sleep_fault(1'b1);
        sc_overvolt();
        sc_wd_count();
        sc_hs_short();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
